/* File: hdl/apr_pin_port.sv */
// Three general-purpose pins with set/clear register pairs and edge event latch.
// Assumes the serial controller presents one-cycle write and read strobes on REF_CLK.
`timescale 1ns/10ps
module apr_pin_port #(
  parameter int PINS = apr_pkg::PIN_COUNT
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_HIT,
  input wire logic [PINS-1:0] PIN_IN,
  output logic [PINS-1:0] PIN_OUT,
  output logic [PINS-1:0] PIN_OE,
  output logic [PINS-1:0] PIN_EVENT
);
  apr_pkg::apr_req_t req;
  apr_pkg::apr_regs_t regs;
  apr_pkg::apr_regs_t next_regs;

  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic [PINS-1:0] prev_in;
  logic armed;
  logic [PINS-1:0] rise_seen;
  logic [PINS-1:0] fall_seen;
  logic [PINS-1:0] rise_hit;
  logic [PINS-1:0] fall_hit;
  logic [PINS-1:0] edge_hit;
  logic [7:0] event_set;
  logic [7:0] in_view;

  logic wr_dir_set;
  logic wr_dir_clear;
  logic wr_out_set;
  logic wr_out_clear;
  logic wr_latch_set;
  logic wr_latch_clear;
  logic wr_fall_set;
  logic wr_fall_clear;
  logic wr_rise_set;
  logic wr_rise_clear;

  logic sel_dir;
  logic sel_out;
  logic sel_in;
  logic sel_latch;
  logic sel_fall;
  logic sel_rise;
  logic known;

  logic [7:0] view_dir;
  logic [7:0] view_out;
  logic [7:0] view_in;
  logic [7:0] view_latch;
  logic [7:0] view_fall;
  logic [7:0] view_rise;
  logic [7:0] rdata_mux;

  logic [7:0] next_dir;
  logic [7:0] next_level;
  logic [7:0] next_latch;
  logic [7:0] next_fall;
  logic [7:0] next_rise;
  logic next_hit;
  logic [7:0] next_rdata;

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // Write decode gives one strobe per address, so a set and a clear never meet.
  // Writes to the input address or to unmapped addresses decode to nothing and are dropped.
  assign wr_dir_set = req.wr && (req.addr == apr_pkg::ADDR_DIR_SET);
  assign wr_dir_clear = req.wr && (req.addr == apr_pkg::ADDR_DIR_CLEAR);
  assign wr_out_set = req.wr && (req.addr == apr_pkg::ADDR_OUT_SET);
  assign wr_out_clear = req.wr && (req.addr == apr_pkg::ADDR_OUT_CLEAR);
  assign wr_latch_set = req.wr && (req.addr == apr_pkg::ADDR_LATCH_SET);
  assign wr_latch_clear = req.wr && (req.addr == apr_pkg::ADDR_LATCH_CLEAR);
  assign wr_fall_set = req.wr && (req.addr == apr_pkg::ADDR_FALL_SET);
  assign wr_fall_clear = req.wr && (req.addr == apr_pkg::ADDR_FALL_CLEAR);
  assign wr_rise_set = req.wr && (req.addr == apr_pkg::ADDR_RISE_SET);
  assign wr_rise_clear = req.wr && (req.addr == apr_pkg::ADDR_RISE_CLEAR);

  // Read decode lets each pair answer on both of its addresses.
  assign sel_dir = (req.addr == apr_pkg::ADDR_DIR_SET)
                || (req.addr == apr_pkg::ADDR_DIR_CLEAR);
  assign sel_out = (req.addr == apr_pkg::ADDR_OUT_SET)
                || (req.addr == apr_pkg::ADDR_OUT_CLEAR);
  assign sel_in = (req.addr == apr_pkg::ADDR_IN);
  assign sel_latch = (req.addr == apr_pkg::ADDR_LATCH_SET)
                  || (req.addr == apr_pkg::ADDR_LATCH_CLEAR);
  assign sel_fall = (req.addr == apr_pkg::ADDR_FALL_SET)
                 || (req.addr == apr_pkg::ADDR_FALL_CLEAR);
  assign sel_rise = (req.addr == apr_pkg::ADDR_RISE_SET)
                 || (req.addr == apr_pkg::ADDR_RISE_CLEAR);
  assign known = sel_dir || sel_out || sel_in || sel_latch || sel_fall || sel_rise;

  // Pad the sampled levels to a byte; unused bits read as zero.
  assign in_view = {{(8-PINS){1'b0}}, sync_b};

  // The selects are exclusive, so an OR of gated views acts as the read mux.
  assign view_dir = sel_dir ? regs.dir : 8'h00;
  assign view_out = sel_out ? regs.level : 8'h00;
  assign view_in = sel_in ? in_view : 8'h00;
  assign view_latch = sel_latch ? regs.latch : 8'h00;
  assign view_fall = sel_fall ? regs.fall : 8'h00;
  assign view_rise = sel_rise ? regs.rise : 8'h00;
  assign rdata_mux = view_dir | view_out | view_in | view_latch | view_fall | view_rise;

  // Edges are trusted from one cycle after reset, while the history register still holds its reset zero.
  // Edges are seen whatever the direction, so a driven pin reports its own changes.
  for (genvar p = 0; p < PINS; p++) begin : g_edge
    assign rise_seen[p] = sync_b[p] & ~prev_in[p];
    assign fall_seen[p] = ~sync_b[p] & prev_in[p];
    assign rise_hit[p] = rise_seen[p] & regs.rise[p];
    assign fall_hit[p] = fall_seen[p] & regs.fall[p];
    assign edge_hit[p] = armed & (rise_hit[p] | fall_hit[p]);
  end

  // Spare bits never see an event.
  assign event_set = {{(8-PINS){1'b0}}, edge_hit};

  // Each pair shares one stored value; its two strobes pick set or clear.
  function automatic logic [7:0] set_clear(input logic [7:0] cur, input logic [7:0] data,
                                           input logic do_set, input logic do_clr);
    logic [7:0] r;
    r = cur;
    if (do_set) begin
      r = cur | data;
    end else if (do_clr) begin
      r = cur & ~data;
    end
    return r;
  endfunction

  assign next_dir = set_clear(regs.dir, req.wdata, wr_dir_set, wr_dir_clear);
  assign next_level = set_clear(regs.level, req.wdata, wr_out_set, wr_out_clear);
  assign next_fall = set_clear(regs.fall, req.wdata, wr_fall_set, wr_fall_clear);
  assign next_rise = set_clear(regs.rise, req.wdata, wr_rise_set, wr_rise_clear);
  // A new event wins over a host clear in the same cycle so no edge is lost.
  assign next_latch = set_clear(regs.latch, req.wdata, wr_latch_set, wr_latch_clear)
                    | event_set;
  assign next_regs = '{dir: next_dir, level: next_level, latch: next_latch,
                       fall: next_fall, rise: next_rise};

  // Read data holds between reads so a slow host can still pick it up.
  assign next_rdata = req.rd ? rdata_mux : REG_RDATA;
  assign next_hit = (req.rd || req.wr) && known;

  // Only the second flop of the synchroniser feeds any logic.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= PIN_IN;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prev_in <= '0;
    end else begin
      prev_in <= sync_b;
    end
  end

  // The first sample after reset has no real predecessor, so edges wait one cycle.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  // All register bits, the five spare ones of each register included, live here.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      regs <= '{default: apr_pkg::RESET_REG};
    end else begin
      regs <= next_regs;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= apr_pkg::RESET_REG;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  // Only mapped addresses answer, so a host can probe for the port.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_HIT <= 1'b0;
    end else begin
      REG_HIT <= next_hit;
    end
  end

  assign PIN_OUT = regs.level[PINS-1:0];
  assign PIN_OE = regs.dir[PINS-1:0];
  assign PIN_EVENT = regs.latch[PINS-1:0];
endmodule

/* File: hdl/apr_pkg.sv */
// Package for the auxiliary pin port: register addresses, widths, reset values and carriers.
// Assumes one register clock and a byte-wide register access port from the serial controller.
package apr_pkg;
  localparam int PIN_COUNT = 3;
  localparam int REG_WIDTH = 8;
  localparam int ADDR_WIDTH = 8;

  localparam logic [7:0] ADDR_DIR_SET = 8'h14;
  localparam logic [7:0] ADDR_DIR_CLEAR = 8'h15;
  localparam logic [7:0] ADDR_OUT_SET = 8'h16;
  localparam logic [7:0] ADDR_OUT_CLEAR = 8'h17;
  localparam logic [7:0] ADDR_IN = 8'h18;
  localparam logic [7:0] ADDR_LATCH_SET = 8'h1a;
  localparam logic [7:0] ADDR_LATCH_CLEAR = 8'h1b;
  localparam logic [7:0] ADDR_FALL_SET = 8'h1c;
  localparam logic [7:0] ADDR_FALL_CLEAR = 8'h1d;
  localparam logic [7:0] ADDR_RISE_SET = 8'h1e;
  localparam logic [7:0] ADDR_RISE_CLEAR = 8'h1f;

  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [2:0] RESET_PINS = 3'h0;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] level;
    logic [7:0] latch;
    logic [7:0] fall;
    logic [7:0] rise;
  } apr_regs_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } apr_req_t;
endpackage

/* File: sim/apr_pin_port_props.sv */
// Checker for the pin port, bound to the top module.
// Assumes the one-cycle strobe port and one-cycle answers of the port.
`timescale 1ns/10ps
module apr_pin_port_props #(parameter int PINS = 3) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_HIT,
  input wire logic [PINS-1:0] PIN_IN,
  input wire logic [PINS-1:0] PIN_OUT,
  input wire logic [PINS-1:0] PIN_OE,
  input wire logic [PINS-1:0] PIN_EVENT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  wire hit = (REG_WR | REG_RD) && REG_ADDR inside {[8'h14:8'h18], [8'h1a:8'h1f]};
  wire lvl = REG_WR && REG_ADDR inside {8'h16, 8'h17};
  wire [PINS-1:0] clr = (REG_WR && REG_ADDR == 8'h1b) ? REG_WDATA[PINS-1:0] : '0;
  wire [PINS-1:0] wlow = REG_WDATA[PINS-1:0];
  sequence s_clr_out;
    REG_WR && REG_ADDR == 8'h17;
  endsequence
  sequence s_rd_out;
    REG_RD && REG_ADDR inside {8'h16, 8'h17};
  endsequence
  sequence s_rd_latch;
    REG_RD && REG_ADDR inside {8'h1a, 8'h1b};
  endsequence
  AST_SET: assert property (REG_WR && REG_ADDR == 8'h16 |=>
    PIN_OUT == $past(PIN_OUT | wlow)) else $error("set failed");
  AST_CLR: assert property (s_clr_out |=>
    PIN_OUT == $past(PIN_OUT & ~wlow)) else $error("clear failed");
  AST_DIR: assert property (REG_WR && REG_ADDR == 8'h14 |=>
    PIN_OE == $past(PIN_OE | wlow)) else $error("direction failed");
  AST_HOLD: assert property (!lvl |=> $stable(PIN_OUT)) else $error("output moved");
  AST_HIT: assert property (REG_HIT |-> $past(hit)) else $error("hit unmapped");
  AST_KEEP: assert property (##1
    (($past(PIN_EVENT) & ~PIN_EVENT & ~$past(clr)) == '0)) else $error("event lost");
  AST_RDHOLD: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  AST_IN: assert property (REG_RD && REG_ADDR == 8'h18 |=>
    REG_RDATA[7:3] == 5'h00) else $error("input high bits");
  AST_HITON: assert property (hit |=> REG_HIT) else $error("mapped access unanswered");
  AST_RDOUT: assert property (s_rd_out |=>
    REG_RDATA[PINS-1:0] == $past(PIN_OUT)) else $error("level read differs");
  AST_RDEV: assert property (s_rd_latch |=>
    REG_RDATA[PINS-1:0] == $past(PIN_EVENT)) else $error("latch read differs");
endmodule
bind apr_pin_port apr_pin_port_props #(.PINS(PINS)) props (
  .REF_CLK(REF_CLK),
  .RSTN(RSTN),
  .REG_WR(REG_WR),
  .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA),
  .REG_HIT(REG_HIT),
  .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE),
  .PIN_EVENT(PIN_EVENT)
);

/* File: sim/apr_host.sv */
// Host model on the strobe port; one access per task call.
// Assumes answers arrive on the same edge that takes the strobe.
`timescale 1ns/10ps
module apr_host (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial {wr, rd, addr, wdata} = 18'h0_0000;
  // Released address and data lines show inverted values and both strobes drop, so stale data is never mistaken for live.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk) #1 {wr, rd, addr, wdata} = {w, !w, a, d};
    @(posedge clk) #1 {wr, rd, addr, wdata} = {2'h0, ~a, ~d};
    q = rdata;
  endtask
endmodule

/* File: sim/apr_pin_port_bench.sv */
// Bench for the pin port: register walks, pin outputs and edge events.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module apr_pin_port_bench;
  logic clk = 0, rstn = 0, wr, rd, hit;
  logic [7:0] addr, wd, rdat, q;
  logic [2:0] pin_in = 3'h0, pout, poe, pev;
  int error_cnt = 0, samples_checked = 0;
  logic [7:0] pair_base [5] = '{8'h14, 8'h16, 8'h1a, 8'h1c, 8'h1e};
  apr_pin_port uut (.REF_CLK(clk), .RSTN(rstn), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_RDATA(rdat), .REG_HIT(hit), .PIN_IN(pin_in), .PIN_OUT(pout),
    .PIN_OE(poe), .PIN_EVENT(pev));
  apr_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wd), .rdata(rdat));
  initial forever #2.5 clk = ~clk;
  task complete_run;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task pins(input logic [2:0] v);
    @(posedge clk) #1 pin_in = v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial #20000 begin
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rstn = 1;
    // Each pair walks the worked set and clear example on both addresses.
    foreach (pair_base[i]) begin
      automatic logic [7:0] s = pair_base[i];
      host.acc(1, s, 8'h28, q);
      host.acc(1, s, 8'h88, q);
      host.acc(0, s + 8'h01, 8'h00, q); `CHK(q, 8'ha8)
      host.acc(1, s + 8'h01, 8'h88, q);
      host.acc(0, s, 8'h00, q); `CHK(q, 8'h20)
    end
    `CHK({pout, poe, pev}, 9'h000)
    host.acc(1, 8'h16, 8'h05, q); `CHK(pout, 3'h5)
    `CHK(hit, 1'b1)
    host.acc(1, 8'h14, 8'h07, q); `CHK(poe, 3'h7)
    host.acc(1, 8'h1e, 8'h01, q);
    host.acc(1, 8'h1c, 8'h02, q);
    pins(3'h2); `CHK(pev, 3'h0)
    pins(3'h1); `CHK(pev, 3'h3)
    host.acc(0, 8'h18, 8'h00, q); `CHK(q, 8'h01)
    host.acc(1, 8'h1b, 8'h01, q); `CHK(pev, 3'h2)
    host.acc(1, 8'h18, 8'hff, q);
    host.acc(0, 8'h18, 8'h00, q); `CHK(q, 8'h01)
    host.acc(0, 8'h19, 8'h00, q); `CHK({q, hit}, 9'h000)
    rstn = 0;
    #10 `CHK({pout, poe, pev}, 9'h000)
    @(posedge clk) #1 rstn = 1;
    host.acc(0, 8'h1e, 8'h00, q); `CHK(q, 8'h00)
    complete_run;
  end
endmodule
